/* File: rtl/pulse_accum_consts.vh */
/*
 Constants for the pulse accumulator and modulus counter block: register
 byte offsets, field positions, reset values and divider figures.
 Assumes inclusion by bare name from the rtl/ design files.
*/
`ifndef PULSE_ACCUM_CONSTS_VH
`define PULSE_ACCUM_CONSTS_VH

// Register byte offsets on the APB slave
`define OFS_ACCUM_CTRL     12'h000
`define OFS_CLOCK_CTRL     12'h004
`define OFS_ACCUM_COUNT    12'h008
`define OFS_ACCUM_HOLD     12'h00C
`define OFS_MOD_CTRL       12'h010
`define OFS_MOD_LOAD       12'h014
`define OFS_MOD_COUNT      12'h018
`define OFS_IRQ_STATUS     12'h01C
`define OFS_IRQ_MASK       12'h020

// Accumulator control field positions
`define BIT_ACCUM_ENABLE   0
`define BIT_ACCUM_MODE     1
`define BIT_ACCUM_EDGE     2
`define BIT_TIMER_ENABLE   3

// Clock control field positions
`define BIT_CLK_SEL_LO     0
`define BIT_CLK_SEL_HI     1
`define BIT_LATCH_CMD      2

// Modulus control field positions
`define BIT_MOD_PRE_LO     0
`define BIT_MOD_PRE_HI     1
`define BIT_MOD_RELOAD     2
`define BIT_MOD_ENABLE     3
`define BIT_MOD_FORCE      4

// Interrupt status bit positions
`define BIT_IRQ_ACCUM      0
`define BIT_IRQ_MOD        1
`define IRQ_BITS           2

// Reset and preset values
`define MOD_PRESET         16'hFFFF
`define ACCUM_RESET        8'h00

// Divider figures
`define GATED_DIV          64
`define ACCUM_DIV_MID      256
`define ACCUM_DIV_HIGH     65536

`endif

/* File: rtl/pulse_edge_sync.v */
/*
 Two-flop synchroniser for the accumulator input pin with rise and fall
 pulses derived from the second and third stages.
 Assumes one clock and a synchronous active-low reset.
*/
module pulse_edge_sync (
   // Clock and reset
   input  wire ref_clk_i,
   input  wire reset_n_i,
   // Pin in
   input  wire pin_i,
   // Clean level and edges
   output wire level_o,
   output wire rise_o,
   output wire fall_o
);
   reg meta_r;    // First stage, read only by the second
   reg sync_r;    // Second stage, clean level
   reg prev_r;    // Delayed clean level for edge detection

   // Synchroniser chain; edges from stages two and three so each counts once
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level_o = sync_r;
   assign rise_o  = sync_r & ~prev_r;
   assign fall_o  = ~sync_r & prev_r;
endmodule // pulse_edge_sync

/* File: rtl/tick_divider.v */
/*
 Free counter that emits a one-cycle tick every DIV input ticks.
 Assumes one clock; clear restarts the count.
*/
module tick_divider #(
   parameter W   = 16,
   parameter DIV = 64
) (
   // Clock and reset
   input  wire ref_clk_i,
   input  wire reset_n_i,
   // Control
   input  wire clear_i,
   input  wire tick_i,
   // Result
   output wire tick_o
);
   localparam integer LAST_I = DIV - 1;          // Terminal count
   localparam [W-1:0] LAST   = LAST_I[W-1:0];   // Cut to W bits on purpose
   reg [W-1:0] cnt_r;                   // Ticks seen so far

   // Count input ticks, wrap at the terminal count
   always @(posedge ref_clk_i) begin
      if (!reset_n_i || clear_i) begin
         cnt_r <= {W{1'b0}};
      end else if (tick_i) begin
         if (cnt_r == LAST) begin
            cnt_r <= {W{1'b0}};
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   assign tick_o = tick_i && (cnt_r == LAST);
endmodule // tick_divider

/* File: rtl/pulse_accum_modulus_counter.v */
/*
 Pulse accumulator A, timer counter clock select, accumulator latch and the
 modulus down-counter, reached over APB with a sticky interrupt status.
 Assumes the input pin is synchronous-ish (it is resynchronised here) and a
 timer prescaler tick arrives as a one-cycle pulse on the bus clock.
*/
`include "pulse_accum_consts.vh"

// Functional notes
// - Mode bit acts only while accumulator enabled
// - Event mode counts rising or falling pin edges
// - Gated, edge 1: count div64 while pin low
// - Gated, edge 0: count div64 while pin high
// - No div64 clock while timer disabled
// - Clock select: prescaler, accum clock, /256, /65536
// - Latch copies accumulator to holding, clears it
// - Forced load only while modulus counter enabled
// - Force-load bit write zero ignored, reads zero
// - Non-reload mode stops at zero
// - Disabled modulus count held at all ones
// - Prescale codes divide by 1, 4, 8, 16
// - New prescale takes effect at next load
module pulse_accum_modulus_counter #(
   parameter ACC_W = 8,
   parameter MOD_W = 16
) (
   // Clock and reset
   input  wire             ref_clk_i,
   input  wire             reset_n_i,
   // APB slave
   input  wire             psel_i,
   input  wire             penable_i,
   input  wire             pwrite_i,
   input  wire [11:0]      paddr_i,
   input  wire [31:0]      pwdata_i,
   output reg  [31:0]      prdata_o,
   output reg              pready_o,
   output reg              pslverr_o,
   // Pins and timer side
   input  wire             accum_input_pin_i,
   input  wire             prescaler_tick_i,
   output reg              counter_clock_tick_o,
   // Interrupt
   output reg              irq_o
);
   // Control registers
   reg              accum_a_enable_r;       // Accumulator enable
   reg              accum_mode_select_r;    // 1 gated, 0 events
   reg              accum_edge_control_r;   // Edge or gate polarity
   reg              timer_enable_bit_r;     // Timer prescaler running
   reg              counter_clock_sel_lo_r; // Counter clock select
   reg              counter_clock_sel_hi_r;
   reg              modulus_prescale_lo_r;  // Written prescale code
   reg              modulus_prescale_hi_r;
   reg              modulus_reload_mode_r;  // 1 reload at zero
   reg              modulus_counter_enable_r;
   reg  [MOD_W-1:0] mod_load_r;             // Load register
   reg  [MOD_W-1:0] mod_count_r;            // Count register
   reg  [1:0]       active_pre_r;           // Prescale code in use
   reg  [3:0]       pre_cnt_r;              // Modulus prescaler
   reg  [ACC_W-1:0] accum_r;                // Pulse accumulator
   reg  [ACC_W-1:0] hold_r;                 // Holding register
   reg  [`IRQ_BITS-1:0] irq_status_r;       // Sticky events
   reg  [`IRQ_BITS-1:0] irq_mask_r;         // Interrupt enables

   // Synchronised pin
   wire pin_level;
   wire pin_rise;
   wire pin_fall;

   pulse_edge_sync u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .pin_i     (accum_input_pin_i),
      .level_o   (pin_level),
      .rise_o    (pin_rise),
      .fall_o    (pin_fall)
   );

   // Bus clock divided by 64, counted only while the timer enable bit is set, so it stops with the timer
   wire div64_tick;
   tick_divider #(.W(7), .DIV(`GATED_DIV)) u_div64 (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .clear_i   (~timer_enable_bit_r),
      .tick_i    (timer_enable_bit_r),
      .tick_o    (div64_tick)
   );

   // Accumulator clock: pin edges or gated div64 pulses
   reg accum_clock;
   reg gate_end;
   always @* begin
      accum_clock = 1'b0;
      gate_end    = 1'b0;
      if (accum_a_enable_r) begin
         if (!accum_mode_select_r) begin
            accum_clock = accum_edge_control_r ? pin_rise : pin_fall;
         end else if (accum_edge_control_r) begin
            accum_clock = div64_tick & ~pin_level;
            gate_end    = pin_rise;
         end else begin
            accum_clock = div64_tick & pin_level;
            gate_end    = pin_fall;
         end
      end
   end

   // Accumulator clock dividers for the counter clock choices
   wire acc_div256;
   wire acc_div65536;
   tick_divider #(.W(9), .DIV(`ACCUM_DIV_MID)) u_div256 (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .clear_i   (1'b0),
      .tick_i    (accum_clock),
      .tick_o    (acc_div256)
   );
   tick_divider #(.W(17), .DIV(`ACCUM_DIV_HIGH)) u_div65536 (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .clear_i   (1'b0),
      .tick_i    (accum_clock),
      .tick_o    (acc_div65536)
   );

   // Counter clock multiplexer
   reg counter_tick_nxt;
   always @* begin
      case ({counter_clock_sel_hi_r, counter_clock_sel_lo_r})
         2'b00:   counter_tick_nxt = prescaler_tick_i;
         2'b01:   counter_tick_nxt = accum_clock;
         2'b10:   counter_tick_nxt = acc_div256;
         2'b11:   counter_tick_nxt = acc_div65536;
         default: counter_tick_nxt = 1'b0;
      endcase
   end

   // APB decode: writes take effect in the access phase, read data is captured at the end of setup
   wire wr_en = psel_i & penable_i & pwrite_i;
   wire mapped = (paddr_i == `OFS_ACCUM_CTRL) || (paddr_i == `OFS_CLOCK_CTRL) ||
                 (paddr_i == `OFS_ACCUM_COUNT) || (paddr_i == `OFS_ACCUM_HOLD) ||
                 (paddr_i == `OFS_MOD_CTRL) || (paddr_i == `OFS_MOD_LOAD) ||
                 (paddr_i == `OFS_MOD_COUNT) || (paddr_i == `OFS_IRQ_STATUS) ||
                 (paddr_i == `OFS_IRQ_MASK);
   wire latch_cmd  = wr_en && (paddr_i == `OFS_CLOCK_CTRL) && pwdata_i[`BIT_LATCH_CMD];
   wire mod_ctl_wr = wr_en && (paddr_i == `OFS_MOD_CTRL);
   // Forced load ignored unless the counter is already enabled
   wire force_load = mod_ctl_wr && pwdata_i[`BIT_MOD_FORCE] && modulus_counter_enable_r;

   // Modulus prescaler tick using the code latched at the last load
   reg pre_tick;
   always @* begin
      case (active_pre_r)
         2'b00:   pre_tick = 1'b1;
         2'b01:   pre_tick = (pre_cnt_r[1:0] == 2'b11);
         2'b10:   pre_tick = (pre_cnt_r[2:0] == 3'b111);
         2'b11:   pre_tick = (pre_cnt_r == 4'b1111);
         default: pre_tick = 1'b0;
      endcase
   end

   // Underflow event: count one reaching zero on a tick
   wire mod_tick  = modulus_counter_enable_r && !force_load && pre_tick;
   wire mod_under = mod_tick && (mod_count_r == {{(MOD_W-1){1'b0}}, 1'b1});
   wire mod_zero  = (mod_count_r == {MOD_W{1'b0}});

   // Control registers and the modulus counter
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         accum_a_enable_r         <= 1'b0;
         accum_mode_select_r      <= 1'b0;
         accum_edge_control_r     <= 1'b0;
         timer_enable_bit_r       <= 1'b0;
         counter_clock_sel_lo_r   <= 1'b0;
         counter_clock_sel_hi_r   <= 1'b0;
         modulus_prescale_lo_r    <= 1'b0;
         modulus_prescale_hi_r    <= 1'b0;
         modulus_reload_mode_r    <= 1'b0;
         modulus_counter_enable_r <= 1'b0;
         mod_load_r               <= {MOD_W{1'b0}};
         mod_count_r              <= `MOD_PRESET;
         active_pre_r             <= 2'b00;
         pre_cnt_r                <= 4'h0;
         irq_mask_r               <= {`IRQ_BITS{1'b0}};
      end else begin
         if (wr_en && paddr_i == `OFS_ACCUM_CTRL) begin
            accum_a_enable_r     <= pwdata_i[`BIT_ACCUM_ENABLE];
            accum_mode_select_r  <= pwdata_i[`BIT_ACCUM_MODE];
            accum_edge_control_r <= pwdata_i[`BIT_ACCUM_EDGE];
            timer_enable_bit_r   <= pwdata_i[`BIT_TIMER_ENABLE];
         end
         if (wr_en && paddr_i == `OFS_CLOCK_CTRL) begin
            counter_clock_sel_lo_r <= pwdata_i[`BIT_CLK_SEL_LO];
            counter_clock_sel_hi_r <= pwdata_i[`BIT_CLK_SEL_HI];
         end
         if (mod_ctl_wr) begin
            // Prescale code stored but not yet used
            modulus_prescale_lo_r    <= pwdata_i[`BIT_MOD_PRE_LO];
            modulus_prescale_hi_r    <= pwdata_i[`BIT_MOD_PRE_HI];
            modulus_reload_mode_r    <= pwdata_i[`BIT_MOD_RELOAD];
            modulus_counter_enable_r <= pwdata_i[`BIT_MOD_ENABLE];
         end
         if (wr_en && paddr_i == `OFS_MOD_LOAD) begin
            mod_load_r <= pwdata_i[MOD_W-1:0];
         end
         if (wr_en && paddr_i == `OFS_IRQ_MASK) begin
            irq_mask_r <= pwdata_i[`IRQ_BITS-1:0];
         end
         // Modulus count register
         if (!modulus_counter_enable_r) begin
            mod_count_r <= `MOD_PRESET;
            pre_cnt_r   <= 4'h0;
         end else if (force_load) begin
            mod_count_r  <= mod_load_r;
            pre_cnt_r    <= 4'h0;
            active_pre_r <= {modulus_prescale_hi_r, modulus_prescale_lo_r};
         end else begin
            pre_cnt_r <= pre_tick ? 4'h0 : pre_cnt_r + 4'h1;
            if (pre_tick && !mod_zero) begin
               if (mod_under && modulus_reload_mode_r) begin
                  mod_count_r  <= mod_load_r;
                  active_pre_r <= {modulus_prescale_hi_r, modulus_prescale_lo_r};
               end else begin
                  mod_count_r <= mod_count_r - 1'b1;
               end
            end
            // At zero with reload off the count simply stays put
         end
      end
   end

   // Accumulator, holding register; latch clear overrides a same-cycle count
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         accum_r <= `ACCUM_RESET;
         hold_r  <= `ACCUM_RESET;
      end else if (latch_cmd) begin
         hold_r  <= accum_r;
         accum_r <= `ACCUM_RESET;
      end else if (accum_clock) begin
         accum_r <= accum_r + 1'b1;
      end
   end

   // Sticky status: set wins over a write-one clear
   reg [`IRQ_BITS-1:0] irq_set;
   reg [`IRQ_BITS-1:0] irq_clr;
   always @* begin
      irq_set = {`IRQ_BITS{1'b0}};
      irq_set[`BIT_IRQ_ACCUM] = gate_end;
      irq_set[`BIT_IRQ_MOD]   = mod_under;
      irq_clr = (wr_en && paddr_i == `OFS_IRQ_STATUS) ? pwdata_i[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};
   end

   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         irq_status_r <= {`IRQ_BITS{1'b0}};
      end else begin
         irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
      end
   end

   // Read multiplexer; command bits always read zero
   reg [31:0] rdata_nxt;
   always @* begin
      rdata_nxt = 32'h0000_0000;
      case (paddr_i)
         `OFS_ACCUM_CTRL: begin
            rdata_nxt[`BIT_ACCUM_ENABLE] = accum_a_enable_r;
            rdata_nxt[`BIT_ACCUM_MODE]   = accum_mode_select_r;
            rdata_nxt[`BIT_ACCUM_EDGE]   = accum_edge_control_r;
            rdata_nxt[`BIT_TIMER_ENABLE] = timer_enable_bit_r;
         end
         `OFS_CLOCK_CTRL: begin
            rdata_nxt[`BIT_CLK_SEL_LO] = counter_clock_sel_lo_r;
            rdata_nxt[`BIT_CLK_SEL_HI] = counter_clock_sel_hi_r;
         end
         `OFS_ACCUM_COUNT: rdata_nxt[ACC_W-1:0] = accum_r;
         `OFS_ACCUM_HOLD:  rdata_nxt[ACC_W-1:0] = hold_r;
         `OFS_MOD_CTRL: begin
            rdata_nxt[`BIT_MOD_PRE_LO] = modulus_prescale_lo_r;
            rdata_nxt[`BIT_MOD_PRE_HI] = modulus_prescale_hi_r;
            rdata_nxt[`BIT_MOD_RELOAD] = modulus_reload_mode_r;
            rdata_nxt[`BIT_MOD_ENABLE] = modulus_counter_enable_r;
         end
         `OFS_MOD_LOAD:   rdata_nxt[MOD_W-1:0] = mod_load_r;
         `OFS_MOD_COUNT:  rdata_nxt[MOD_W-1:0] = mod_count_r;
         `OFS_IRQ_STATUS: rdata_nxt[`IRQ_BITS-1:0] = irq_status_r;
         `OFS_IRQ_MASK:   rdata_nxt[`IRQ_BITS-1:0] = irq_mask_r;
         default:         rdata_nxt = 32'h0000_0000;
      endcase
   end

   // Registered outputs; pready is a one-cycle pulse that rises with penable, after the setup cycle
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         prdata_o             <= 32'h0000_0000;
         pready_o             <= 1'b0;
         pslverr_o            <= 1'b0;
         counter_clock_tick_o <= 1'b0;
         irq_o                <= 1'b0;
      end else begin
         pready_o             <= psel_i & ~penable_i;
         pslverr_o            <= psel_i & ~penable_i & ~mapped;
         prdata_o             <= (psel_i & ~penable_i & ~pwrite_i) ? rdata_nxt : prdata_o;
         counter_clock_tick_o <= counter_tick_nxt;
         irq_o                <= |(((irq_status_r & ~irq_clr) | irq_set) & irq_mask_r);
      end
   end

endmodule // pulse_accum_modulus_counter

/* File: tb/pulse_accum_props.sv */
/* Checker for the pulse accumulator block: APB handshake, read-as-zero
   bits, preset count, clock select and interrupt masking.
   Assumes a bind to the top module and the design header on the path. */
`include "pulse_accum_consts.vh"
module pulse_accum_props (
   // Clock and reset
   input wire        ref_clk_i,
   input wire        reset_n_i,
   // APB
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   // Pins and interrupt
   input wire        accum_input_pin_i,
   input wire        prescaler_tick_i,
   input wire        counter_clock_tick_o,
   input wire        irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   wire       wr_take = psel_i & penable_i & pready_o & pwrite_i;  // Write lands
   wire       rd_take = psel_i & penable_i & pready_o & !pwrite_i; // Read taken
   reg  [1:0] sel_r;   // Snooped clock select
   reg  [1:0] mask_r;  // Snooped interrupt mask
   reg        moden_r; // Snooped modulus enable
   // Shadow the few control fields that the assertions depend on
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         sel_r   <= 2'b00;
         mask_r  <= 2'b00;
         moden_r <= 1'b0;
      end else if (wr_take) begin
         if (paddr_i == `OFS_CLOCK_CTRL) sel_r <= pwdata_i[1:0];
         if (paddr_i == `OFS_IRQ_MASK) mask_r <= pwdata_i[1:0];
         if (paddr_i == `OFS_MOD_CTRL) moden_r <= pwdata_i[`BIT_MOD_ENABLE];
      end
   end
   a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("pready late");
   a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("pready held");
   a_ready_in_access: assert property (pready_o |-> psel_i && penable_i) else $error("stray pready");
   a_err_unmapped: assert property (pready_o && !pwrite_i && paddr_i > `OFS_IRQ_MASK
      |-> pslverr_o && prdata_o == 32'h0000_0000) else $error("unmapped read accepted");
   a_err_mapped: assert property (pready_o && paddr_i <= `OFS_IRQ_MASK && paddr_i[1:0] == 2'b00
      |-> !pslverr_o) else $error("mapped access refused");
   a_force_reads_zero: assert property (rd_take && paddr_i == `OFS_MOD_CTRL
      |-> !prdata_o[`BIT_MOD_FORCE]) else $error("force bit read one");
   a_latch_reads_zero: assert property (rd_take && paddr_i == `OFS_CLOCK_CTRL
      |-> !prdata_o[`BIT_LATCH_CMD]) else $error("latch bit read one");
   a_preset_count: assert property (rd_take && paddr_i == `OFS_MOD_COUNT && !moden_r
      |-> prdata_o[15:0] == `MOD_PRESET) else $error("disabled count not preset");
   a_sel_prescaler: assert property (sel_r == 2'b00 && $past(sel_r) == 2'b00 && $past(reset_n_i)
      |-> counter_clock_tick_o == $past(prescaler_tick_i)) else $error("tick not from prescaler");
   a_irq_masked: assert property (mask_r == 2'b00 && $past(mask_r) == 2'b00 && $past(reset_n_i)
      |-> !irq_o) else $error("masked interrupt raised");
   cover property (wr_take);
   cover property (rd_take && pslverr_o);
   cover property ($rose(irq_o));
   cover property (counter_clock_tick_o && sel_r == 2'b10);
endmodule // pulse_accum_props

bind pulse_accum_modulus_counter pulse_accum_props u_props (
   .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .accum_input_pin_i(accum_input_pin_i),
   .prescaler_tick_i(prescaler_tick_i), .counter_clock_tick_o(counter_clock_tick_o), .irq_o(irq_o));

/* File: tb/pulse_source_model.sv */
/* External pulse source on the accumulator input pin: on request it sends
   a train of pulses away from an idle level, each phase width cycles.
   Assumes requests come as a one-cycle start after a clock edge. */
module pulse_source_model (
   // Clock
   input  wire        ref_clk_i,
   // Request
   input  wire        start_i,
   input  wire        idle_lvl_i,
   input  wire [15:0] count_i,
   input  wire [15:0] width_i,
   // Pin and status
   output logic       pin_o,
   output logic       busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // The pin is always driven, so it never floats between trains
   initial begin
      pin_o = 1'b0;
      busy_o = 1'b0;
      forever begin
         @(posedge ref_clk_i);
         if (start_i) begin
            busy_o <= 1'b1;
            for (int n = 0; n < count_i; n++) begin
               pin_o <= !idle_lvl_i;
               repeat (width_i) @(posedge ref_clk_i);
               pin_o <= idle_lvl_i;
               repeat (width_i) @(posedge ref_clk_i);
            end
            busy_o <= 1'b0;
         end else pin_o <= idle_lvl_i;
      end
   end
endmodule // pulse_source_model

/* File: tb/tb_top.sv */
/* Self-checking bench for the pulse accumulator and modulus counter.
   Assumes the design header is on the include path. */
`include "pulse_accum_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [31:0] prdata_o, rdq;           // Read data, last value taken
   logic        pready_o, pslverr_o, rerr, irq_o, tick_o, pin, busy;
   logic        go = 1'b0, idle = 1'b0, pre_tick = 1'b0;
   logic [15:0] n_pulse = 16'h0000, width = 16'h0004;
   int          cyc, rcyc, ticks, t0, fail_count, compares;
   pulse_accum_modulus_counter u_dut (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .accum_input_pin_i(pin),
      .prescaler_tick_i(pre_tick), .counter_clock_tick_o(tick_o), .irq_o(irq_o));
   pulse_source_model u_src (.ref_clk_i(ref_clk_i), .start_i(go), .idle_lvl_i(idle),
      .count_i(n_pulse), .width_i(width), .pin_o(pin), .busy_o(busy));
   initial forever #25 ref_clk_i = ~ref_clk_i;
   // Cycle count and a prescaler tick every 8 cycles, quiet in reset
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      pre_tick <= reset_n_i && (cyc % 8 == 7);
   end
   // Counted mid-cycle so the sample never races the launching edge
   always @(negedge ref_clk_i) if (tick_o === 1'b1) ticks++;
   task automatic chk(input logic [31:0] got, input int lo, input int hi);
      compares++;
      if ($isunknown(got) || got < lo || got > hi) begin
         fail_count++;
         $display("ERROR %0t got %0h want %0h..%0h", $time, got, lo, hi);
      end
   endtask
   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge ref_clk_i);
      psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do begin @(posedge ref_clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
      chk(n, 1, 19);
      rdq = prdata_o;
      rerr = pslverr_o;
      rcyc = cyc;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
   task automatic rd(input logic [11:0] a); apb(1'b0, a, 32'h0000_0000); endtask
   task automatic pulses(input int n, input int w);
      int k = 0;
      n_pulse <= n[15:0];
      width <= w[15:0];
      go <= 1'b1;
      @(posedge ref_clk_i);
      go <= 1'b0;
      do begin @(posedge ref_clk_i); k++; end while (busy === 1'b1 && k < 5000);
      repeat (6) @(posedge ref_clk_i);  // Margin; last edge already through the synchroniser
   endtask
   task automatic pick(input int s);
      wr(`OFS_CLOCK_CTRL, s);
      repeat (2) @(posedge ref_clk_i);  // Let a tick from the old source drain
      t0 = ticks;
   endtask
   task automatic t_reset;
      rd(`OFS_MOD_COUNT); chk(rdq, 16'hFFFF, 16'hFFFF);
      rd(`OFS_ACCUM_COUNT); chk(rdq, 0, 0);
      rd(12'h040); chk(rdq, 0, 0);
      chk(rerr, 1, 1);
      $display("test reset done");
   endtask
   task automatic t_event;
      for (int e = 0; e < 2; e++) begin
         idle <= !e[0];  // Idle away from the counted edge
         repeat (4) @(posedge ref_clk_i);
         wr(`OFS_ACCUM_CTRL, e << `BIT_ACCUM_EDGE);  // Still disabled
         pulses(3, 4);
         wr(`OFS_ACCUM_CTRL, 1 | e << `BIT_ACCUM_EDGE);
         pulses(5, 4);
         rd(`OFS_ACCUM_COUNT); chk(rdq, 5, 5);
         wr(`OFS_CLOCK_CTRL, 4);
         rd(`OFS_ACCUM_HOLD); chk(rdq, 5, 5);
         rd(`OFS_ACCUM_COUNT); chk(rdq, 0, 0);
         rd(`OFS_CLOCK_CTRL); chk(rdq, 0, 0);
         wr(`OFS_ACCUM_CTRL, 0);
      end
      $display("test event done");
   endtask
   task automatic t_gated;
      logic e, tmr;
      for (int i = 0; i < 3; i++) begin
         e = (i != 1);
         tmr = (i != 2);
         idle <= e;  // Inactive level equals the edge bit
         repeat (4) @(posedge ref_clk_i);
         wr(`OFS_IRQ_MASK, 1);
         wr(`OFS_ACCUM_CTRL, 3 | e << `BIT_ACCUM_EDGE | tmr << `BIT_TIMER_ENABLE);
         wr(`OFS_CLOCK_CTRL, 4);
         wr(`OFS_IRQ_STATUS, 3);
         pulses(1, 640);
         rd(`OFS_ACCUM_COUNT); chk(rdq, tmr ? 9 : 0, tmr ? 11 : 0);
         rd(`OFS_IRQ_STATUS); chk(rdq, 1, 1);
         chk(irq_o, 1, 1);
         wr(`OFS_IRQ_STATUS, 1);
         rd(`OFS_IRQ_STATUS); chk(rdq, 0, 0);
         chk(irq_o, 0, 0);
         wr(`OFS_ACCUM_CTRL, 0);
      end
      $display("test gated done");
   endtask
   task automatic t_clksel;
      pick(0); repeat (400) @(posedge ref_clk_i); chk(ticks - t0, 49, 51);
      idle <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      wr(`OFS_ACCUM_CTRL, 5);
      pick(1); pulses(20, 4); chk(ticks - t0, 20, 20);
      pick(2); pulses(256, 3); chk(ticks - t0, 1, 1);
      pick(3); pulses(256, 3); chk(ticks - t0, 0, 0);
      pick(0);
      wr(`OFS_ACCUM_CTRL, 0);
      $display("test clock select done");
   endtask
   // Counts down across a window and compares with the cycles elapsed
   task automatic measure(input int div);
      logic [31:0] a;
      int ca;
      rd(`OFS_MOD_COUNT);
      a = rdq;
      ca = rcyc;
      repeat (300) @(posedge ref_clk_i);
      rd(`OFS_MOD_COUNT);
      chk(a - rdq, (rcyc - ca) / div - 1, (rcyc - ca) / div + 1);
   endtask
   task automatic t_modulus;
      int dv[4] = '{1, 4, 8, 16};
      wr(`OFS_IRQ_MASK, 2);
      wr(`OFS_MOD_LOAD, 20);
      wr(`OFS_MOD_CTRL, 16);  // Force while disabled
      rd(`OFS_MOD_COUNT); chk(rdq, 16'hFFFF, 16'hFFFF);
      wr(`OFS_MOD_CTRL, 8);
      wr(`OFS_MOD_CTRL, 24);
      rd(`OFS_MOD_CTRL); chk(rdq, 8, 8);
      repeat (40) @(posedge ref_clk_i);
      rd(`OFS_MOD_COUNT); chk(rdq, 0, 0);
      rd(`OFS_IRQ_STATUS); chk(rdq, 2, 2);
      chk(irq_o, 1, 1);
      wr(`OFS_IRQ_MASK, 0);
      rd(`OFS_IRQ_STATUS);
      chk(rdq, 2, 2);
      chk(irq_o, 0, 0);
      wr(`OFS_IRQ_STATUS, 2);
      repeat (20) @(posedge ref_clk_i);
      rd(`OFS_IRQ_STATUS); chk(rdq, 0, 0);
      wr(`OFS_MOD_LOAD, 10);
      wr(`OFS_MOD_CTRL, 28);
      repeat (30) @(posedge ref_clk_i);
      wr(`OFS_IRQ_STATUS, 2);
      repeat (12) @(posedge ref_clk_i);
      rd(`OFS_IRQ_STATUS); chk(rdq, 2, 2);
      rd(`OFS_MOD_COUNT); chk(rdq, 0, 10);
      wr(`OFS_MOD_LOAD, 60000);
      wr(`OFS_MOD_CTRL, 24);
      measure(1);
      for (int c = 1; c < 4; c++) begin
         wr(`OFS_MOD_CTRL, 8 | c);
         measure(dv[c - 1]);
         wr(`OFS_MOD_CTRL, 24 | c);
         measure(dv[c]);
      end
      wr(`OFS_MOD_CTRL, 0);
      rd(`OFS_MOD_COUNT); chk(rdq, 16'hFFFF, 16'hFFFF);
      $display("test modulus done");
   endtask
   task automatic results;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      t_reset;
      t_event;
      t_gated;
      t_clksel;
      t_modulus;
      results;
   end
   // Watchdog, well beyond the expected run
   initial begin
      #2000000;
      fail_count++;
      $display("ERROR %0t watchdog expired", $time);
      results;
   end
endmodule // tb_top
